// >>> rtl/pidc_pkg.sv
// Shared constants for the paged/interleaved DRAM controller.
// Assumes a single 10 MHz clock domain and an I/O index/data port pair.
package pidc_pkg;
    // Indirect configuration port
    localparam logic [7:0] IO_INDEX_PORT   = 8'h22;
    localparam logic [7:0] IO_DATA_PORT    = 8'h23;
    localparam logic [7:0] DRAM_CONFIG_IDX = 8'h16;
    localparam logic [7:0] BANK_DENS_IDX   = 8'h15;
    // dram_config fields
    localparam int INTERLEAVE_BIT = 1;
    localparam int PAGE_BIT       = 2;
    localparam int PARITY_BIT     = 5;
    localparam int SLOW_REF_BIT   = 6;
    localparam int WAIT_LO        = 0;
    localparam logic [7:0] DRAM_CONFIG_RST = 8'h00;
    localparam logic [7:0] BANK_DENS_RST   = 8'h00;
    // Bank density codes
    localparam logic [1:0] DENS_NONE = 2'h0;
    localparam logic [1:0] DENS_256K = 2'h1;
    localparam logic [1:0] DENS_1M   = 2'h2;
    localparam logic [1:0] DENS_4M   = 2'h3;
    localparam int NUM_BANKS = 4;
    localparam int ROW_W     = 11;
    localparam int ADDR_W    = 24;
    // Extra row-setup cycles when the address manager warns of a mapped access
    localparam logic [1:0] MAP_SETUP_CYC = 2'h1;
    localparam logic [1:0] MAX_WAIT      = 2'h2;
endpackage

// >>> rtl/pidc_bank_map.sv
// Bank, row and column decode from a word address and bank densities.
// Assumes banks fill linearly from bank 0 up to a 16 Mb total.
`timescale 1ns/1ps
`default_nettype none
module pidc_bank_map (
    input  wire logic [23:0] word_addr,
    input  wire logic [7:0]  bank_dens,
    input  wire logic [1:0]  ilv_ways,
    output logic             hit_any,
    output logic [1:0]       bank_sel,
    output logic [10:0]      row_addr,
    output logic [10:0]      col_addr
);
    // Words held by one bank for a density code
    function automatic logic [23:0] bank_words(input logic [1:0] d);
        case (d)
            pidc_pkg::DENS_256K: bank_words = 24'h040000;
            pidc_pkg::DENS_1M:   bank_words = 24'h100000;
            pidc_pkg::DENS_4M:   bank_words = 24'h400000;
            default:             bank_words = 24'h000000;
        endcase
    endfunction

    // Bases are one bit wider so a fully populated array does not wrap to zero
    logic [24:0] base [0:4];
    logic [23:0] off;
    logic [23:0] sh;
    logic [1:0]  lin_bank;
    logic        lin_hit;

    assign base[0] = 25'h0000000;
    genvar g;
    generate
        for (g = 0; g < pidc_pkg::NUM_BANKS; g++) begin : g_base
            assign base[g+1] = base[g] + {1'b0, bank_words(bank_dens[2*g +: 2])};
        end
    endgenerate

    always_comb begin
        lin_bank = 2'h0;
        lin_hit  = 1'b0;
        off      = 24'h000000;
        for (int b = pidc_pkg::NUM_BANKS - 1; b >= 0; b--) begin
            if ({1'b0, word_addr} >= base[b] && {1'b0, word_addr} < base[b+1]) begin
                lin_bank = 2'(b);
                lin_hit  = 1'b1;
                off      = word_addr - base[b][23:0];
            end
        end
    end

    // Interleave: low word bits pick the bank, the rest index inside it
    always_comb begin
        if (ilv_ways == 2'h2) begin
            bank_sel = {1'b0, word_addr[0]} | {lin_bank[1], 1'b0};
            sh       = (word_addr - base[{lin_bank[1], 1'b0}][23:0]) >> 1;
        end else if (ilv_ways == 2'h3) begin
            bank_sel = word_addr[1:0];
            sh       = word_addr >> 2;
        end else begin
            bank_sel = lin_bank;
            sh       = off;
        end
    end

    assign hit_any  = lin_hit;
    assign col_addr = sh[10:0];
    assign row_addr = sh[21:11];
endmodule
`default_nettype wire

// >>> rtl/pidc_parity.sv
// Byte parity generation and masked checking for one data word.
// Assumes odd parity per byte, combinational.
`timescale 1ns/1ps
`default_nettype none
module pidc_parity (
    input  wire logic [15:0] data,
    input  wire logic [1:0]  par_in,
    input  wire logic        check_en,
    output logic [1:0]       par_gen,
    output logic             par_err
);
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_byte
            assign par_gen[i] = ~^data[8*i +: 8];
        end
    endgenerate
    assign par_err = check_en & (par_gen != par_in);
endmodule
`default_nettype wire

// >>> rtl/pidc_ctrl.sv
// Paged/interleaved four-bank DRAM controller with indirect config port.
// Assumes CPU requests are synchronous to mclk and held until mem_ack.
`timescale 1ns/1ps
`default_nettype none
module pidc_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // I/O port access
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    // CPU memory request
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [23:0] mem_waddr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        map_warn,
    output logic             mem_claim,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata,
    output logic             par_error,
    // DRAM pins
    output logic [10:0]      mem_addr_bus,
    output logic [3:0]       ras_n,
    output logic [1:0]       cas_n,
    output logic             write_en_high_n,
    output logic             write_en_low_n,
    output logic [15:0]      dq_out,
    output logic [1:0]       dqp_out,
    output logic             dq_oe,
    input  wire logic [15:0] dq_in,
    input  wire logic [1:0]  dqp_in
);
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_ROW   = 6'b000010,
        ST_RAS   = 6'b000100,
        ST_COL   = 6'b001000,
        ST_CAS   = 6'b010000,
        ST_DONE  = 6'b100000
    } pidc_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [7:0] index_r;
    logic [7:0] dram_config_r;
    logic [7:0] bank_density_cfg_r;
    logic [7:0] dram_config_nxt;
    logic       sel_cfg;
    logic       sel_dens;
    logic       wr_data;
    logic       srb_prev_r;
    logic       cmp_clear;

    assign sel_cfg  = index_r == pidc_pkg::DRAM_CONFIG_IDX;
    assign sel_dens = index_r == pidc_pkg::BANK_DENS_IDX;
    assign wr_data  = io_wr && io_addr == pidc_pkg::IO_DATA_PORT;
    assign dram_config_nxt = (wr_data && sel_cfg) ? io_wdata : dram_config_r;
    // Any change of the slow refresh bit clears the page comparator
    assign cmp_clear = dram_config_r[pidc_pkg::SLOW_REF_BIT] != srb_prev_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            index_r            <= 8'h00;
            dram_config_r      <= pidc_pkg::DRAM_CONFIG_RST;
            bank_density_cfg_r <= pidc_pkg::BANK_DENS_RST;
            srb_prev_r         <= 1'b0;
        end else begin
            if (io_wr && io_addr == pidc_pkg::IO_INDEX_PORT)
                index_r <= io_wdata;
            dram_config_r <= dram_config_nxt;
            if (wr_data && sel_dens)
                bank_density_cfg_r <= io_wdata;
            srb_prev_r <= dram_config_r[pidc_pkg::SLOW_REF_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
        end else if (io_rd && io_addr == pidc_pkg::IO_DATA_PORT) begin
            io_rdata <= sel_cfg ? dram_config_r :
                        sel_dens ? bank_density_cfg_r : 8'h00;
        end else if (io_rd && io_addr == pidc_pkg::IO_INDEX_PORT) begin
            io_rdata <= index_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    logic       page_enable;
    logic       interleave_enable;
    logic       pair_lo;
    logic       pair_hi;
    logic       all_four;
    logic [1:0] ilv_ways;
    logic [1:0] wait_min;

    assign page_enable       = dram_config_r[pidc_pkg::PAGE_BIT];
    assign interleave_enable = dram_config_r[pidc_pkg::INTERLEAVE_BIT] & page_enable;
    assign pair_lo  = bank_density_cfg_r[1:0] != pidc_pkg::DENS_NONE &&
                      bank_density_cfg_r[1:0] == bank_density_cfg_r[3:2];
    assign pair_hi  = bank_density_cfg_r[5:4] != pidc_pkg::DENS_NONE &&
                      bank_density_cfg_r[5:4] == bank_density_cfg_r[7:6];
    assign all_four = pair_lo && pair_hi && bank_density_cfg_r[1:0] == bank_density_cfg_r[5:4];
    // Illegal combinations fall back to linear banking
    assign ilv_ways = !interleave_enable ? 2'h0 :
                      all_four ? 2'h3 :
                      (pair_lo && (pair_hi || bank_density_cfg_r[5:4] == pidc_pkg::DENS_NONE))
                      ? 2'h2 : 2'h0;
    assign wait_min = (dram_config_r[pidc_pkg::WAIT_LO +: 2] > pidc_pkg::MAX_WAIT)
                      ? pidc_pkg::MAX_WAIT : dram_config_r[pidc_pkg::WAIT_LO +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Address decode and parity
    logic        hit_any;
    logic [1:0]  bank_sel;
    logic [10:0] row_addr;
    logic [10:0] col_addr;
    logic [1:0]  par_gen_w;
    logic [1:0]  par_gen_r;
    logic        par_err_r;

    pidc_bank_map u_map (
        .word_addr (mem_waddr),
        .bank_dens (bank_density_cfg_r),
        .ilv_ways  (ilv_ways),
        .hit_any   (hit_any),
        .bank_sel  (bank_sel),
        .row_addr  (row_addr),
        .col_addr  (col_addr)
    );

    pidc_parity u_par_wr (
        .data     (mem_wdata),
        .par_in   (2'h0),
        .check_en (1'b0),
        .par_gen  (par_gen_w),
        .par_err  ()
    );

    pidc_parity u_par_rd (
        .data     (dq_in),
        .par_in   (dqp_in),
        .check_en (dram_config_r[pidc_pkg::PARITY_BIT]),
        .par_gen  (par_gen_r),
        .par_err  (par_err_r)
    );

    ////////////////////////////////////////////////////////////////////////
    // Page comparator
    logic [10:0] open_row_r [0:3];
    logic [3:0]  row_valid_r;
    logic        page_hit;

    assign page_hit = page_enable && row_valid_r[bank_sel] &&
                      open_row_r[bank_sel] == row_addr;

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    pidc_state_t state_r;
    logic [1:0]  cnt_r;
    logic        we_r;
    logic [1:0]  bank_r;
    logic [10:0] row_r;
    logic [10:0] col_r;
    logic        start;

    assign start = mem_req && hit_any && !mem_ack;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= 2'h0;
            we_r    <= 1'b0;
            bank_r  <= 2'h0;
            row_r   <= 11'h000;
            col_r   <= 11'h000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        we_r   <= mem_we;
                        bank_r <= bank_sel;
                        row_r  <= row_addr;
                        col_r  <= col_addr;
                        cnt_r  <= map_warn ? pidc_pkg::MAP_SETUP_CYC : 2'h0;
                        // Open-row hit skips row phase and waits
                        state_r <= page_hit ? ST_COL : ST_ROW;
                    end
                end
                ST_ROW: begin
                    if (cnt_r == 2'h0) state_r <= ST_RAS;
                    else cnt_r <= cnt_r - 2'h1;
                end
                ST_RAS: begin
                    state_r <= ST_COL;
                    cnt_r   <= wait_min;
                end
                ST_COL: begin
                    state_r <= ST_CAS;
                end
                ST_CAS: begin
                    if (cnt_r == 2'h0) state_r <= ST_DONE;
                    else cnt_r <= cnt_r - 2'h1;
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Comparator update; clearing wins over a same-cycle load
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            row_valid_r <= 4'h0;
            for (int b = 0; b < pidc_pkg::NUM_BANKS; b++) open_row_r[b] <= 11'h000;
        end else if (cmp_clear) begin
            row_valid_r <= 4'h0;
        end else if (state_r == ST_RAS && page_enable) begin
            row_valid_r[bank_r] <= 1'b1;
            open_row_r[bank_r]  <= row_r;
        end else if (!page_enable) begin
            row_valid_r <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    logic [3:0] ras_nxt;
    logic       in_access;

    assign in_access = state_r == ST_RAS || state_r == ST_COL ||
                       state_r == ST_CAS || state_r == ST_DONE;
    always_comb begin
        ras_nxt = 4'hf;
        if (page_enable && !cmp_clear)
            ras_nxt = ~row_valid_r;
        // A row change must close the open row before the new row strobe
        if (state_r == ST_ROW)
            ras_nxt[bank_r] = 1'b1;
        if (in_access && state_r != ST_DONE)
            ras_nxt[bank_r] = 1'b0;
        if (in_access && state_r == ST_DONE && page_enable)
            ras_nxt[bank_r] = 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mem_addr_bus    <= 11'h000;
            ras_n           <= 4'hf;
            cas_n           <= 2'h3;
            write_en_high_n <= 1'b1;
            write_en_low_n  <= 1'b1;
            dq_out          <= 16'h0000;
            dqp_out         <= 2'h0;
            dq_oe           <= 1'b0;
            mem_ack         <= 1'b0;
            mem_claim       <= 1'b0;
            mem_rdata       <= 16'h0000;
            par_error       <= 1'b0;
        end else begin
            // Row address stays on the bus while the row strobe falls
            mem_addr_bus <= (state_r == ST_ROW || state_r == ST_RAS) ? row_r : col_r;
            ras_n        <= ras_nxt;
            cas_n        <= (state_r == ST_CAS) ? 2'h0 : 2'h3;
            write_en_high_n <= !(we_r && (state_r == ST_COL || state_r == ST_CAS));
            write_en_low_n  <= !(we_r && (state_r == ST_COL || state_r == ST_CAS));
            dq_oe        <= we_r && state_r != ST_IDLE && state_r != ST_DONE;
            if (start) begin
                dq_out  <= mem_wdata;
                dqp_out <= par_gen_w;
            end
            mem_claim    <= mem_req && hit_any;
            mem_ack      <= state_r == ST_DONE;
            if (state_r == ST_DONE && !we_r) begin
                mem_rdata <= dq_in;
                par_error <= par_err_r;
            end
            if (!dram_config_r[pidc_pkg::PARITY_BIT])
                par_error <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_reset_mode: assert property (@(posedge mclk)
        $rose(rst_n) |-> !page_enable && !interleave_enable)
        else $error("mode not cleared by reset");
    chk_no_bank_claim: assert property (@(posedge mclk) disable iff (!rst_n)
        bank_density_cfg_r == 8'h00 |=> !mem_claim)
        else $error("claimed with no banks");
    chk_srb_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        cmp_clear |=> row_valid_r == 4'h0)
        else $error("comparator not cleared");
    chk_row_then_ras: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_ROW && cnt_r == 2'h0 |=> state_r == ST_RAS ##1 state_r == ST_COL)
        else $error("row sequence broken");
    chk_cas_waits: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_RAS && wait_min == 2'h2 |=> ST_COL == state_r ##1 ST_CAS == state_r
        [*3] ##1 state_r == ST_DONE)
        else $error("wait count wrong");
    chk_hit_no_row: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_IDLE && start && page_hit |=> state_r == ST_COL)
        else $error("page hit took row phase");
    chk_bad_ilv: assert property (@(posedge mclk) disable iff (!rst_n)
        !pair_lo |-> ilv_ways == 2'h0)
        else $error("interleave on mismatched banks");
    chk_write_en: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_CAS && we_r |=> !write_en_high_n && !write_en_low_n)
        else $error("write enables missing");
    chk_map_stretch: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_IDLE && start && !page_hit && map_warn |=> state_r == ST_ROW [*2])
        else $error("mapped setup not stretched");
    chk_row_addr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_RAS |=> mem_addr_bus == row_r)
        else $error("row address not held at row strobe");
    chk_row_precharge: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_ROW |=> ras_n[bank_r])
        else $error("row strobe not closed before new row");
endmodule
`default_nettype wire

// >>> verif/pidc_dram_model.sv
// Behavioural model of four page-mode DRAM banks on one muxed address bus.
// Assumes strobes and write data from the controller; bad_par corrupts read parity.
`timescale 1ns/1ps
`default_nettype none
module pidc_dram_model (
    input  wire logic        mclk,
    input  wire logic [3:0]  ras_n,
    input  wire logic [1:0]  cas_n,
    input  wire logic [10:0] mem_addr_bus,
    input  wire logic        write_en_high_n,
    input  wire logic        write_en_low_n,
    input  wire logic [15:0] dq_out,
    input  wire logic [1:0]  dqp_out,
    input  wire logic        bad_par,
    output logic      [15:0] dq_in,
    output logic      [1:0]  dqp_in
);
    logic [17:0] cells [logic [23:0]];
    logic [10:0] row_r [4];
    logic [3:0]  ras_q = 4'hf;
    logic        cas_q = 1'b1;
    logic [1:0]  bank;
    logic [23:0] key;
    logic [17:0] rd_now;
    logic [17:0] rd_r = 18'h0;
    logic        hold_r = 1'b0;
    logic        live;
    logic [17:0] dout;

    assign bank = ras_n[0] ? (ras_n[1] ? (ras_n[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
    assign live = !(&cas_n) && write_en_high_n && write_en_low_n;
    always @* begin
        key = {bank, row_r[bank], mem_addr_bus};
        rd_now = cells.exists(key) ? cells[key] : 18'h0;
    end
    // Released bus holds the last word for one cycle, then shows its inverse
    assign dout = live ? rd_now : (hold_r ? rd_r : ~rd_r);
    assign dq_in = dout[15:0];
    assign dqp_in = dout[17:16] ^ {2{bad_par}};

    always @(posedge mclk) begin
        for (int b = 0; b < 4; b++)
            if (ras_q[b] && !ras_n[b]) row_r[b] = mem_addr_bus;
        if (cas_q && !(&cas_n) && !(write_en_high_n && write_en_low_n))
            cells[key] = {dqp_out, dq_out};
        hold_r <= live;
        if (live) rd_r <= rd_now;
        ras_q <= ras_n;
        cas_q <= &cas_n;
    end
endmodule
`default_nettype wire

// >>> verif/test_paged_interleaved_dram_ctrl.sv
// Bench for the DRAM controller: config port, access modes, waits, parity.
// Assumes the DRAM model is compiled first and the design needs no parameters.
`timescale 1ns/1ps
`default_nettype none
module test_paged_interleaved_dram_ctrl;
    logic        mclk, rst_n, io_wr, io_rd, mem_req, mem_we, map_warn, bad_par;
    logic        mem_claim, mem_ack, par_error, wen_h_n, wen_l_n, dq_oe, wen_seen;
    logic [7:0]  io_addr, io_wdata, io_rdata, v;
    logic [23:0] mem_waddr;
    logic [15:0] mem_wdata, mem_rdata, dq_out, dq_in, rd;
    logic [10:0] mem_addr_bus;
    logic [3:0]  ras_n, ras_q;
    logic [1:0]  cas_n, dqp_out, dqp_in, wpar;
    logic        cas_q;
    int          err_count, checks_done, ras_falls, last_bank, lat, m, f;
    int          lat0 [2];
    time         t_ras, t_cas;

    pidc_ctrl pidc_ctrl_i (.mclk(mclk), .rst_n(rst_n), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_req(mem_req),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .map_warn(map_warn),
        .mem_claim(mem_claim), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .par_error(par_error), .mem_addr_bus(mem_addr_bus), .ras_n(ras_n), .cas_n(cas_n),
        .write_en_high_n(wen_h_n), .write_en_low_n(wen_l_n), .dq_out(dq_out),
        .dqp_out(dqp_out), .dq_oe(dq_oe), .dq_in(dq_in), .dqp_in(dqp_in));
    pidc_dram_model pidc_dram_model_i (.mclk(mclk), .ras_n(ras_n), .cas_n(cas_n),
        .mem_addr_bus(mem_addr_bus), .write_en_high_n(wen_h_n), .write_en_low_n(wen_l_n),
        .dq_out(dq_out), .dqp_out(dqp_out), .bad_par(bad_par), .dq_in(dq_in),
        .dqp_in(dqp_in));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin monitor: strobe edges and write-cycle contents
    always @(posedge mclk) begin
        for (int b = 0; b < 4; b++)
            if (ras_q[b] && !ras_n[b]) begin
                ras_falls++;
                last_bank = b;
                t_ras = $time;
            end
        if (cas_q && !(&cas_n)) t_cas = $time;
        if (!wen_h_n && !wen_l_n) wen_seen = 1'b1;
        if (dq_oe) wpar = dqp_out;
        ras_q <= ras_n;
        cas_q <= &cas_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, s, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic io_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_wr = wr;
        io_rd = !wr;
        io_addr = a;
        io_wdata = d;
        @(negedge mclk);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask
    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] val);
        io_op(1'b1, 8'h22, idx);
        io_op(1'b1, 8'h23, val);
    endtask
    task automatic cfg_rd(input logic [7:0] idx);
        io_op(1'b1, 8'h22, idx);
        io_op(1'b0, 8'h23, 8'h00);
        @(negedge mclk);
        v = io_rdata;
    endtask
    task automatic set_mode(input logic [7:0] val);
        cfg_wr(8'h16, val);
        cfg_wr(8'h16, val | 8'h40);
        cfg_wr(8'h16, val);
    endtask
    task automatic access(input logic we, input logic [23:0] a, input logic [15:0] d,
                          input logic warn);
        @(negedge mclk);
        mem_req = 1'b1;
        mem_we = we;
        mem_waddr = a;
        mem_wdata = d;
        map_warn = warn;
        wen_seen = 1'b0;
        lat = 0;
        do begin
            @(posedge mclk);
            #1;
            lat++;
        end while (mem_ack !== 1'b1 && lat < 40);
        check(mem_ack, 1'b1, "access acknowledge");
        rd = mem_rdata;
        @(negedge mclk);
        mem_req = 1'b0;
        mem_we = 1'b0;
        map_warn = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        cfg_rd(8'h16);
        check(v, 8'h00, "config after reset");
        cfg_rd(8'h15);
        check(v, 8'h00, "densities after reset");
        @(negedge mclk);
        mem_req = 1'b1;
        f = 0;
        repeat (20) begin
            @(posedge mclk);
            #1;
            if (mem_claim !== 1'b0 || mem_ack !== 1'b0) f++;
        end
        @(negedge mclk);
        mem_req = 1'b0;
        check(f, 0, "no bank installed but answered");
    endtask
    task automatic t_regs;
        cfg_wr(8'h15, 8'h03);
        cfg_rd(8'h15);
        check(v, 8'h03, "density readback");
        cfg_rd(8'h10);
        check(v, 8'h00, "unused index");
    endtask
    task automatic t_nonpaged;
        for (int w = 0; w < 2; w++) begin
            cfg_wr(8'h16, 8'(w));
            access(1'b1, 24'h10 + w, 16'ha5c2 + w, 1'b0);
            check(mem_claim, 1'b1, "installed bank claimed");
            check(wen_seen, 1'b1, "write enables");
            check(wpar, {~^(8'ha5), ~^(8'hc2 + w)}, "write parity");
            access(1'b0, 24'h10 + w, 16'h0, 1'b0);
            check(rd, 16'ha5c2 + w, "read data");
            check(t_ras < t_cas, 1'b1, "row before column strobe");
            lat0[w] = lat;
        end
        check(lat0[1] - lat0[0], 1, "one wait state");
        access(1'b0, 24'h11, 16'h0, 1'b1);
        check(lat - lat0[1], 1, "mapped access stretch");
    endtask
    task automatic t_paged;
        set_mode(8'h04);
        access(1'b0, 24'h20, 16'h0, 1'b0);
        m = lat;
        f = ras_falls;
        access(1'b0, 24'h21, 16'h0, 1'b0);
        check(lat < m, 1'b1, "page hit faster");
        check(ras_falls - f, 0, "row strobe reopened");
        check(ras_n[0], 1'b0, "row strobe open when idle");
        access(1'b0, 24'h820, 16'h0, 1'b0);
        check(lat, m, "row change latency");
        check(ras_falls - f, 1, "row change reopens strobe");
    endtask
    task automatic t_parity;
        set_mode(8'h00);
        cfg_wr(8'h16, 8'h20);
        access(1'b0, 24'h10, 16'h0, 1'b0);
        check(par_error, 1'b0, "good parity flagged");
        bad_par = 1'b1;
        access(1'b0, 24'h10, 16'h0, 1'b0);
        bad_par = 1'b0;
        check(par_error, 1'b1, "bad parity missed");
        cfg_wr(8'h16, 8'h00);
        @(negedge mclk);
        check(par_error, 1'b0, "parity error not cleared");
    endtask
    task automatic t_ilv;
        cfg_wr(8'h15, 8'h07);
        set_mode(8'h06);
        f = ras_falls;
        access(1'b0, 24'h0, 16'h0, 1'b0);
        access(1'b0, 24'h1, 16'h0, 1'b0);
        check(ras_falls - f, 1, "interleave with unequal banks");
        check(last_bank, 0, "bank for unequal banks");
        set_mode(8'h00);
        cfg_wr(8'h15, 8'hff);
        set_mode(8'h06);
        for (int k = 0; k < 4; k++) begin
            access(1'b0, 24'(k), 16'h0, 1'b0);
            check(last_bank, k, "bank rotation");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, io_wr, io_rd, mem_req, mem_we, map_warn, bad_par} = 7'h0;
        {io_addr, io_wdata, mem_waddr, mem_wdata} = 56'h0;
        {ras_q, cas_q, wen_seen, wpar} = 8'hf8;
        {err_count, checks_done, ras_falls, last_bank} = 128'h0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_nonpaged();
        t_paged();
        t_parity();
        t_ilv();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
